//--- logic/smd_pkg.sv
// shared constants for the stall motion detector
package smd_pkg;
    localparam int CLK_HZ = 50000000;
    // sample delay table in microseconds, low and high pwm rate columns
    localparam int DELAY_LO_US_0 = 87;
    localparam int DELAY_LO_US_1 = 130;
    localparam int DELAY_LO_US_2 = 174;
    localparam int DELAY_LO_US_3 = 217;
    localparam int DELAY_LO_US_4 = 261;
    localparam int DELAY_LO_US_5 = 304;
    localparam int DELAY_LO_US_6 = 348;
    localparam int DELAY_LO_US_7 = 391;
    localparam int DELAY_HI_US_0 = 43;
    localparam int DELAY_HI_US_1 = 65;
    localparam int DELAY_HI_US_2 = 87;
    localparam int DELAY_HI_US_3 = 109;
    localparam int DELAY_HI_US_4 = 130;
    localparam int DELAY_HI_US_5 = 152;
    localparam int DELAY_HI_US_6 = 174;
    localparam int DELAY_HI_US_7 = 196;
    localparam int CYC_PER_US = CLK_HZ / 1000000;
    // two-phase move pause, microseconds
    localparam int PHASE_PAUSE_US = 26600;
    localparam int PHASE_PAUSE_CYC = PHASE_PAUSE_US * CYC_PER_US;
    // threshold steps in millivolts; back-emf input is in millivolts
    localparam int ABS_STEP_MV = 500;
    localparam int DELTA_STEP_MV = 250;
    localparam int BEMF_W = 14;
    localparam int POS_W = 16;
    localparam int AVG_SHIFT = 3;
    localparam logic [3:0] THR_RESET = 4'h0;
    localparam logic [2:0] FIELD3_RESET = 3'h0;
    localparam int FULL_DUTY_OPTION_BIT = 1;
    typedef enum logic [2:0] {
        SMD_IDLE = 3'b000,
        SMD_RAMP = 3'b001,
        SMD_ARM = 3'b010,
        SMD_WATCH = 3'b011,
        SMD_PAUSE = 3'b100
    } smd_state_e;
endpackage

//--- logic/smd_delay_timer.sv
// cycle countdown timer: one-cycle done pulse after a loaded count
module smd_delay_timer (
    input wire logic clk_sys,
    input wire logic rstSync_n,
    input wire logic load,
    input wire logic [20:0] count,
    output logic done,
    output logic busy
);
    logic [20:0] remain;

    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            remain <= 21'h000000;
            done <= 1'b0;
            busy <= 1'b0;
        end else if (load) begin
            remain <= count;
            done <= 1'b0;
            busy <= 1'b1;
        end else if (busy) begin
            remain <= remain - 21'h000001;
            done <= (remain == 21'h000001);
            busy <= (remain != 21'h000001);
        end else begin
            done <= 1'b0;
        end
    end
endmodule

//--- logic/smd_bemf_average.sv
// moving average of back-emf samples (exponential, weight 1/8)
module smd_bemf_average (
    input wire logic clk_sys,
    input wire logic rstSync_n,
    input wire logic sampleValid,
    input wire logic restart,
    input wire logic [smd_pkg::BEMF_W-1:0] sample,
    output logic [smd_pkg::BEMF_W-1:0] average
);
    logic [smd_pkg::BEMF_W+smd_pkg::AVG_SHIFT-1:0] acc;
    logic primed;
    wire [smd_pkg::BEMF_W+smd_pkg::AVG_SHIFT-1:0] wideSample =
        {{smd_pkg::AVG_SHIFT{1'b0}}, sample};
    wire [smd_pkg::BEMF_W+smd_pkg::AVG_SHIFT-1:0] nextAcc =
        acc - (acc >> smd_pkg::AVG_SHIFT) + wideSample;

    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            acc <= '0;
            primed <= 1'b0;
        end else if (restart) begin
            primed <= 1'b0;
        end else if (sampleValid) begin
            // first sample seeds the average so it does not ramp from zero
            acc <= primed ? nextAcc : (wideSample << smd_pkg::AVG_SHIFT);
            primed <= 1'b1;
        end
    end

    assign average = acc[smd_pkg::BEMF_W+smd_pkg::AVG_SHIFT-1:
                         smd_pkg::AVG_SHIFT];
endmodule

//--- logic/stall_motion_detector.sv
// stall motion detector: back-emf thresholds, stall flags and hard stop
module stall_motion_detector (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [smd_pkg::BEMF_W-1:0] bemfMv,
    input wire logic pwmPeriodStart,
    input wire logic fullStep,
    input wire logic atMaxVelocity,
    input wire logic moveActive,
    input wire logic twoPhaseMove,
    input wire logic pwmFullDuty,
    input wire logic [smd_pkg::POS_W-1:0] stepCounter,
    input wire logic full_status_read_cmd,
    input wire logic stall_param_write_cmd,
    input wire logic otp_param_write_cmd,
    input wire logic bemf_test_cmd,
    input wire logic [3:0] cmdAbsThreshold,
    input wire logic [3:0] cmdDeltaThreshold,
    input wire logic [2:0] cmdSampleDelay,
    input wire logic [2:0] cmdStepDelay,
    input wire logic [7:0] cmdData7,
    input wire logic pwm_rate_select,
    input wire logic switch_input_pin,
    output logic delStallLo,
    output logic delStallHi,
    output logic absStall,
    output logic stallFlag,
    output logic lost_step_flag,
    output logic hardStop,
    output logic secondPhaseStart,
    output logic [smd_pkg::POS_W-1:0] actual_position,
    output logic qualificationMode,
    output logic switchState,
    output logic [3:0] absolute_threshold_index,
    output logic [3:0] delta_threshold_index,
    output logic [2:0] bemf_sample_delay,
    output logic [2:0] stall_enable_step_delay,
    output logic full_duty_stall_option
);
    ////////////////////////////////////////////////////////////////////////
    logic rstMeta_n;
    logic rstSync_n;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_n <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta_n <= 1'b1;
            rstSync_n <= rstMeta_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // otp store and working copy
    // blank otp reads as zero; its writes survive every later reset
    logic [3:0] otpAbs = smd_pkg::THR_RESET;
    logic [3:0] otpDelta = smd_pkg::THR_RESET;
    logic [2:0] otpSample = smd_pkg::FIELD3_RESET;
    logic [2:0] otpStep = smd_pkg::FIELD3_RESET;
    logic otpFullDuty = 1'b0;
    logic otpLoaded;

    // one cycle after reset release the working copy reloads from otp
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            otpLoaded <= 1'b0;
        end else begin
            otpLoaded <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (otp_param_write_cmd) begin
            otpAbs <= cmdAbsThreshold;
            otpDelta <= cmdDeltaThreshold;
            otpSample <= cmdSampleDelay;
            otpStep <= cmdStepDelay;
            otpFullDuty <= cmdData7[smd_pkg::FULL_DUTY_OPTION_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            absolute_threshold_index <= smd_pkg::THR_RESET;
            delta_threshold_index <= smd_pkg::THR_RESET;
            bemf_sample_delay <= smd_pkg::FIELD3_RESET;
            stall_enable_step_delay <= smd_pkg::FIELD3_RESET;
            full_duty_stall_option <= 1'b0;
        end else if (!otpLoaded) begin
            absolute_threshold_index <= otpAbs;
            delta_threshold_index <= otpDelta;
            bemf_sample_delay <= otpSample;
            stall_enable_step_delay <= otpStep;
            full_duty_stall_option <= otpFullDuty;
        end else if (stall_param_write_cmd) begin
            absolute_threshold_index <= cmdAbsThreshold;
            delta_threshold_index <= cmdDeltaThreshold;
            bemf_sample_delay <= cmdSampleDelay;
            stall_enable_step_delay <= cmdStepDelay;
            full_duty_stall_option <= cmdData7[smd_pkg::FULL_DUTY_OPTION_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // threshold levels in millivolts
    wire [smd_pkg::BEMF_W-1:0] absLevel =
        smd_pkg::BEMF_W'(absolute_threshold_index * smd_pkg::ABS_STEP_MV);
    wire [smd_pkg::BEMF_W-1:0] deltaLevel =
        smd_pkg::BEMF_W'(delta_threshold_index * smd_pkg::DELTA_STEP_MV);
    wire absEnabled = (absolute_threshold_index != 4'h0);
    wire deltaEnabled = (delta_threshold_index != 4'h0);
    wire detectEnabled = absEnabled || deltaEnabled;
    wire full_duty_stall_disable =
        full_duty_stall_option && pwmFullDuty;

    ////////////////////////////////////////////////////////////////////////
    // sample delay lookup, microseconds to cycles
    logic [8:0] delayUs;

    always_comb begin
        delayUs = 9'h000;
        if (pwm_rate_select) begin
            case (bemf_sample_delay)
                3'h0: delayUs = 9'(smd_pkg::DELAY_HI_US_0);
                3'h1: delayUs = 9'(smd_pkg::DELAY_HI_US_1);
                3'h2: delayUs = 9'(smd_pkg::DELAY_HI_US_2);
                3'h3: delayUs = 9'(smd_pkg::DELAY_HI_US_3);
                3'h4: delayUs = 9'(smd_pkg::DELAY_HI_US_4);
                3'h5: delayUs = 9'(smd_pkg::DELAY_HI_US_5);
                3'h6: delayUs = 9'(smd_pkg::DELAY_HI_US_6);
                default: delayUs = 9'(smd_pkg::DELAY_HI_US_7);
            endcase
        end else begin
            case (bemf_sample_delay)
                3'h0: delayUs = 9'(smd_pkg::DELAY_LO_US_0);
                3'h1: delayUs = 9'(smd_pkg::DELAY_LO_US_1);
                3'h2: delayUs = 9'(smd_pkg::DELAY_LO_US_2);
                3'h3: delayUs = 9'(smd_pkg::DELAY_LO_US_3);
                3'h4: delayUs = 9'(smd_pkg::DELAY_LO_US_4);
                3'h5: delayUs = 9'(smd_pkg::DELAY_LO_US_5);
                3'h6: delayUs = 9'(smd_pkg::DELAY_LO_US_6);
                default: delayUs = 9'(smd_pkg::DELAY_LO_US_7);
            endcase
        end
    end

    // at most 391 us of 50 cycles each, well inside 21 bits
    wire [20:0] sampleDelayCyc = 21'(delayUs * smd_pkg::CYC_PER_US);
    wire [20:0] pauseCyc = 21'(smd_pkg::PHASE_PAUSE_CYC);

    ////////////////////////////////////////////////////////////////////////
    // state machine
    smd_pkg::smd_state_e state;
    smd_pkg::smd_state_e next_state;
    // full steps still to pass before watching starts
    logic [2:0] stepsLeft;
    logic stallEvent;
    logic pauseDone;
    logic sampleDone;
    logic sampleBusy;

    always_comb begin
        next_state = state;
        case (state)
            smd_pkg::SMD_IDLE:
                if (moveActive && detectEnabled) begin
                    next_state = smd_pkg::SMD_RAMP;
                end
            smd_pkg::SMD_RAMP:
                if (!moveActive) begin
                    next_state = smd_pkg::SMD_IDLE;
                end else if (atMaxVelocity) begin
                    next_state = (stall_enable_step_delay == 3'h0) ?
                        smd_pkg::SMD_WATCH : smd_pkg::SMD_ARM;
                end
            smd_pkg::SMD_ARM:
                if (!moveActive || !atMaxVelocity) begin
                    next_state = smd_pkg::SMD_IDLE;
                end else if (fullStep && stepsLeft == 3'h1) begin
                    next_state = smd_pkg::SMD_WATCH;
                end
            smd_pkg::SMD_WATCH:
                if (stallEvent) begin
                    next_state = twoPhaseMove ?
                        smd_pkg::SMD_PAUSE : smd_pkg::SMD_IDLE;
                end else if (!moveActive || !atMaxVelocity) begin
                    next_state = smd_pkg::SMD_IDLE;
                end
            smd_pkg::SMD_PAUSE:
                if (pauseDone) begin
                    next_state = smd_pkg::SMD_IDLE;
                end
            default: next_state = smd_pkg::SMD_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state <= smd_pkg::SMD_IDLE;
            stepsLeft <= 3'h0;
        end else begin
            state <= next_state;
            if (state == smd_pkg::SMD_RAMP) begin
                stepsLeft <= stall_enable_step_delay;
            end else if (state == smd_pkg::SMD_ARM && fullStep) begin
                stepsLeft <= stepsLeft - 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sampling: at most one comparison per pwm period, after the sample delay
    // a ramp or move end in the evaluation cycle itself must not stop
    wire watching = (state == smd_pkg::SMD_WATCH) && atMaxVelocity &&
        moveActive && !full_duty_stall_disable;
    wire sampleLoad = watching && pwmPeriodStart && !sampleBusy;
    // the pause runs only after a stall in a first phase
    wire pauseLoad = (state == smd_pkg::SMD_WATCH) && stallEvent &&
        twoPhaseMove;

    smd_delay_timer sampleTimer (
        .clk_sys(clk_sys),
        .rstSync_n(rstSync_n),
        .load(sampleLoad),
        .count(sampleDelayCyc),
        .done(sampleDone),
        .busy(sampleBusy)
    );

    smd_delay_timer pauseTimer (
        .clk_sys(clk_sys),
        .rstSync_n(rstSync_n),
        .load(pauseLoad),
        .count(pauseCyc),
        .done(pauseDone),
        .busy()
    );

    logic [smd_pkg::BEMF_W-1:0] average;
    // a timer may finish after leaving watch; such samples are dropped
    wire sampleTake = sampleDone && watching;

    smd_bemf_average averager (
        .clk_sys(clk_sys),
        .rstSync_n(rstSync_n),
        .sampleValid(sampleTake),
        .restart(state == smd_pkg::SMD_IDLE),
        .sample(bemfMv),
        .average(average)
    );

    wire [smd_pkg::BEMF_W:0] upperBound = {1'b0, average} + {1'b0, deltaLevel};
    // a low bound below zero can never be crossed
    wire lowUnder = (deltaLevel > average);
    wire [smd_pkg::BEMF_W-1:0] lowerBound = average - deltaLevel;
    wire hitHi = deltaEnabled && ({1'b0, bemfMv} > upperBound);
    wire hitLo = deltaEnabled && !lowUnder &&
        (bemfMv < lowerBound);
    wire hitAbs = absEnabled && (bemfMv < absLevel);
    assign stallEvent = sampleTake && (hitHi || hitLo || hitAbs);

    ////////////////////////////////////////////////////////////////////////
    // flags: a new stall wins over a clear in the same cycle
    wire clr = full_status_read_cmd;
    wire next_delStallLo = (stallEvent && hitLo) || (delStallLo && !clr);
    wire next_delStallHi = (stallEvent && hitHi) || (delStallHi && !clr);
    wire next_absStall = (stallEvent && hitAbs) || (absStall && !clr);
    wire next_stallFlag = stallEvent || (stallFlag && !clr);
    wire next_lost_step_flag = stallEvent ||
        (lost_step_flag && !clr);

    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            delStallLo <= 1'b0;
            delStallHi <= 1'b0;
            absStall <= 1'b0;
            stallFlag <= 1'b0;
            lost_step_flag <= 1'b0;
        end else begin
            delStallLo <= next_delStallLo;
            delStallHi <= next_delStallHi;
            absStall <= next_absStall;
            stallFlag <= next_stallFlag;
            lost_step_flag <= next_lost_step_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stop pulse and position capture share the stall cycle
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            hardStop <= 1'b0;
            secondPhaseStart <= 1'b0;
            actual_position <= '0;
        end else begin
            hardStop <= stallEvent;
            secondPhaseStart <= pauseDone;
            if (stallEvent) begin
                actual_position <= stepCounter;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // qualification mode is sticky until the next reset on rst_n
    wire switchReadable = !qualificationMode && !bemf_test_cmd;
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            qualificationMode <= 1'b0;
            switchState <= 1'b0;
        end else begin
            if (bemf_test_cmd) begin
                qualificationMode <= 1'b1;
            end
            if (switchReadable) begin
                switchState <= switch_input_pin;
            end
        end
    end
endmodule

//--- verification/smd_motion_source.sv
// partner model: pwm period starts and full-step pulses of a running motor
module smd_motion_source #(
    parameter int PWM_PERIOD = 2500,
    parameter int STEP_PERIOD = 600
) (
    input wire logic clk_sys,
    input wire logic run,
    output logic pwmPeriodStart = 1'h0,
    output logic fullStep = 1'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    int pwmCount = 0;
    int stepCount = 0;
    // counters restart with each move so sample instants are repeatable
    always @(posedge clk_sys) begin
        pwmCount <= run ? (pwmCount + 1) % PWM_PERIOD : 0;
        stepCount <= run ? (stepCount + 1) % STEP_PERIOD : 0;
        pwmPeriodStart <= run && (pwmCount == PWM_PERIOD - 1);
        fullStep <= run && (stepCount == STEP_PERIOD - 1);
    end
endmodule

//--- verification/smd_checker_sva.sv
// concurrent checks on the stall motion detector ports
module smd_checker (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic atMaxVelocity,
    input wire logic pwmFullDuty,
    input wire logic [smd_pkg::POS_W-1:0] stepCounter,
    input wire logic full_status_read_cmd,
    input wire logic stall_param_write_cmd,
    input wire logic bemf_test_cmd,
    input wire logic [3:0] cmdAbsThreshold,
    input wire logic [3:0] cmdDeltaThreshold,
    input wire logic delStallLo,
    input wire logic delStallHi,
    input wire logic absStall,
    input wire logic stallFlag,
    input wire logic lost_step_flag,
    input wire logic hardStop,
    input wire logic [smd_pkg::POS_W-1:0] actual_position,
    input wire logic qualificationMode,
    input wire logic switchState,
    input wire logic [3:0] absolute_threshold_index,
    input wire logic [3:0] delta_threshold_index,
    input wire logic full_duty_stall_option
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    logic thrZero;
    assign thrZero = absolute_threshold_index == 4'h0
        && delta_threshold_index == 4'h0;
    a_stall_or_flags: assert property (
        stallFlag == (delStallLo | delStallHi | absStall))
        else $error("stall flag differs from OR of flags");
    a_stop_sets_flags: assert property (
        hardStop |-> stallFlag && lost_step_flag)
        else $error("hard stop without stall and lost-step flags");
    a_pos_capture: assert property (
        hardStop |-> actual_position == $past(stepCounter))
        else $error("position not captured on hard stop");
    a_status_clears: assert property (
        $past(full_status_read_cmd) && !hardStop
        |-> !stallFlag && !lost_step_flag && !absStall)
        else $error("flags not cleared by status read");
    a_lost_sticky: assert property (
        $past(lost_step_flag) && !$past(full_status_read_cmd)
        |-> lost_step_flag)
        else $error("lost-step flag dropped without status read");
    a_zero_thr_off: assert property (
        $past(thrZero) && thrZero |-> !hardStop)
        else $error("stop with both thresholds zero");
    a_ramp_no_stop: assert property (
        !$past(atMaxVelocity) |-> !hardStop)
        else $error("stop while not at maximum velocity");
    a_full_duty_off: assert property (
        $past(pwmFullDuty && full_duty_stall_option) |-> !hardStop)
        else $error("stop at full duty with option set");
    a_qual_entry: assert property (
        bemf_test_cmd |=> qualificationMode [*3])
        else $error("qualification mode not entered or lost");
    a_switch_frozen: assert property (
        $past(qualificationMode) |-> $stable(switchState))
        else $error("switch state changed in qualification mode");
    a_param_write: assert property (
        stall_param_write_cmd |=> absolute_threshold_index
        == $past(cmdAbsThreshold) && delta_threshold_index
        == $past(cmdDeltaThreshold))
        else $error("working thresholds not written");
    c_hard_stop: cover property (hardStop);
    c_clear_stall: cover property (full_status_read_cmd && stallFlag);
    c_qual_mode: cover property ($rose(qualificationMode));
endmodule

bind stall_motion_detector smd_checker chk (.clk_sys, .rst_n,
    .atMaxVelocity, .pwmFullDuty, .stepCounter, .full_status_read_cmd,
    .stall_param_write_cmd, .bemf_test_cmd, .cmdAbsThreshold,
    .cmdDeltaThreshold, .delStallLo, .delStallHi, .absStall, .stallFlag,
    .lost_step_flag, .hardStop, .actual_position, .qualificationMode,
    .switchState, .absolute_threshold_index, .delta_threshold_index,
    .full_duty_stall_option);

//--- verification/tb_stall_motion_detector.sv
// self-checking bench for the stall motion detector
`define CHECK(what, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("unexpected %s: expected %h, seen %h", what, exp, got); \
        end \
    end
module tb_stall_motion_detector;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PERIOD = 2500;
    // seven moves of five pwm periods plus set-up, with margin
    localparam int LIMIT = 95000;
    int failures = 0;
    int tests_run = 0;
    int stops = 0;
    int phases = 0;
    int cycles = 0;
    logic clk_sys = 1'h0;
    logic rst_n = 1'h0;
    logic run = 1'h0;
    logic [smd_pkg::BEMF_W-1:0] bemfMv = '0;
    logic [smd_pkg::POS_W-1:0] stepCounter = '0;
    logic atMaxVelocity = 1'h0, moveActive = 1'h0, twoPhaseMove = 1'h0;
    logic pwmFullDuty = 1'h0, pwm_rate_select = 1'h1;
    logic full_status_read_cmd = 1'h0, stall_param_write_cmd = 1'h0;
    logic otp_param_write_cmd = 1'h0, bemf_test_cmd = 1'h0;
    logic [3:0] cmdAbsThreshold = 4'h0, cmdDeltaThreshold = 4'h0;
    logic [2:0] cmdSampleDelay = 3'h0, cmdStepDelay = 3'h2;
    logic [7:0] cmdData7 = 8'h00;
    logic switch_input_pin = 1'h0;
    logic pwmPeriodStart, fullStep, delStallLo, delStallHi, absStall;
    logic stallFlag, lost_step_flag, hardStop, secondPhaseStart;
    logic qualificationMode, switchState, full_duty_stall_option;
    logic [smd_pkg::POS_W-1:0] actual_position;
    logic [3:0] absolute_threshold_index, delta_threshold_index;
    logic [2:0] bemf_sample_delay, stall_enable_step_delay;

    smd_motion_source #(.PWM_PERIOD(PERIOD), .STEP_PERIOD(600)) src (
        .clk_sys, .run, .pwmPeriodStart, .fullStep);
    stall_motion_detector dut (.clk_sys, .rst_n, .bemfMv, .pwmPeriodStart,
        .fullStep, .atMaxVelocity, .moveActive, .twoPhaseMove, .pwmFullDuty,
        .stepCounter, .full_status_read_cmd, .stall_param_write_cmd,
        .otp_param_write_cmd, .bemf_test_cmd, .cmdAbsThreshold,
        .cmdDeltaThreshold, .cmdSampleDelay, .cmdStepDelay, .cmdData7,
        .pwm_rate_select, .switch_input_pin, .delStallLo, .delStallHi,
        .absStall, .stallFlag, .lost_step_flag, .hardStop, .secondPhaseStart,
        .actual_position, .qualificationMode, .switchState,
        .absolute_threshold_index, .delta_threshold_index,
        .bemf_sample_delay, .stall_enable_step_delay,
        .full_duty_stall_option);

    always #10 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        if (hardStop === 1'h1) begin
            stops++;
        end
        if (secondPhaseStart === 1'h1) begin
            phases++;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (failures == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            final_report();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask

    task automatic set_params(input logic [3:0] ab, input logic [3:0] dl,
                              input logic [7:0] d7, input logic otp);
        cmdAbsThreshold = ab;
        cmdDeltaThreshold = dl;
        cmdData7 = d7;
        stall_param_write_cmd = !otp;
        otp_param_write_cmd = otp;
        tick(1);
        stall_param_write_cmd = 1'h0;
        otp_param_write_cmd = 1'h0;
        tick(2);
    endtask

    // three periods settle the average, two more carry the disturbance
    task automatic move(input logic [13:0] b0, input logic [13:0] b1,
                        input logic maxv);
        stops = 0;
        bemfMv = b0;
        moveActive = 1'h1;
        atMaxVelocity = maxv;
        run = 1'h1;
        tick(3 * PERIOD);
        bemfMv = b1;
        tick(2 * PERIOD);
        moveActive = 1'h0;
        atMaxVelocity = 1'h0;
        run = 1'h0;
        tick(4);
    endtask

    task automatic flags(input logic lo, input logic hi, input logic ab,
                         input logic stop);
        `CHECK("delStallLo", lo, delStallLo)
        `CHECK("delStallHi", hi, delStallHi)
        `CHECK("absStall", ab, absStall)
        `CHECK("stallFlag", lo | hi | ab, stallFlag)
        `CHECK("lost_step_flag", stop, lost_step_flag)
        `CHECK("hardStop seen", stop, stops != 0)
    endtask

    task automatic clear();
        full_status_read_cmd = 1'h1;
        tick(1);
        full_status_read_cmd = 1'h0;
        tick(2);
        stops = 0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        tick(8);
        rst_n = 1'h1;
        tick(4);
        `CHECK("abs index", 4'h0, absolute_threshold_index)
        set_params(4'h2, 4'hF, 8'h00, 1'h0);
        `CHECK("abs index", 4'h2, absolute_threshold_index)
        `CHECK("delta index", 4'hF, delta_threshold_index)
        stepCounter = 16'h1234;
        move(14'h0BB8, 14'h0320, 1'h1);
        flags(1'h0, 1'h0, 1'h1, 1'h1);
        `CHECK("position", 16'h1234, actual_position)
        clear();
        flags(1'h0, 1'h0, 1'h0, 1'h0);
        set_params(4'h0, 4'h4, 8'h00, 1'h0);
        stepCounter = 16'hA55A;
        move(14'h0BB8, 14'h1194, 1'h1);
        flags(1'h0, 1'h1, 1'h0, 1'h1);
        `CHECK("position", 16'hA55A, actual_position)
        clear();
        move(14'h0BB8, 14'h05DC, 1'h1);
        flags(1'h1, 1'h0, 1'h0, 1'h1);
        clear();
        set_params(4'h0, 4'h0, 8'h00, 1'h0);
        move(14'h0BB8, 14'h0000, 1'h1);
        flags(1'h0, 1'h0, 1'h0, 1'h0);
        set_params(4'h2, 4'hF, 8'h02, 1'h0);
        `CHECK("full duty option", 1'h1, full_duty_stall_option)
        move(14'h0BB8, 14'h0320, 1'h0);
        flags(1'h0, 1'h0, 1'h0, 1'h0);
        pwmFullDuty = 1'h1;
        move(14'h0BB8, 14'h0320, 1'h1);
        flags(1'h0, 1'h0, 1'h0, 1'h0);
        pwmFullDuty = 1'h0;
        switch_input_pin = 1'h1;
        tick(3);
        `CHECK("switchState", 1'h1, switchState)
        bemf_test_cmd = 1'h1;
        tick(1);
        bemf_test_cmd = 1'h0;
        tick(1);
        `CHECK("qualificationMode", 1'h1, qualificationMode)
        switch_input_pin = 1'h0;
        tick(3);
        `CHECK("switchState", 1'h1, switchState)
        // low rate column: second sample lands after the drop
        pwm_rate_select = 1'h0;
        twoPhaseMove = 1'h1;
        move(14'h0BB8, 14'h0320, 1'h1);
        flags(1'h0, 1'h0, 1'h1, 1'h1);
        `CHECK("secondPhaseStart seen", 1'h0, phases != 0)
        cmdSampleDelay = 3'h2;
        cmdStepDelay = 3'h6;
        set_params(4'h5, 4'h3, 8'h02, 1'h1);
        `CHECK("abs index", 4'h2, absolute_threshold_index)
        rst_n = 1'h0;
        tick(8);
        rst_n = 1'h1;
        tick(4);
        `CHECK("abs index", 4'h5, absolute_threshold_index)
        `CHECK("delta index", 4'h3, delta_threshold_index)
        `CHECK("sample delay", 3'h2, bemf_sample_delay)
        `CHECK("step delay", 3'h6, stall_enable_step_delay)
        `CHECK("full duty option", 1'h1, full_duty_stall_option)
        `CHECK("qualificationMode", 1'h0, qualificationMode)
        final_report();
    end
endmodule
